// >>> shared/lbaa_defines.vh
// Offsets, reset values, field positions and timing for the activity alarm.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef LBAA_DEFINES_VH
`define LBAA_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define LBAA_ADDR_HARD_LIMIT 8'h4c
`define LBAA_ADDR_SET_LEVEL 8'h50
`define LBAA_ADDR_CLEAR_LEVEL 8'h51
`define LBAA_ADDR_BUCKET_SIZE 8'h52
`define LBAA_ADDR_LEAK_RATE 8'h53
`define LBAA_ADDR_ALARM_STATUS 8'h54
`define LBAA_ADDR_FILL_BASE 8'h58

////////////////////////////////////////////////////////////////////////////
// Reset values
`define LBAA_RST_HARD_LIMIT 8'h8e
`define LBAA_RST_SET_LEVEL 8'h06
`define LBAA_RST_CLEAR_LEVEL 8'h04
`define LBAA_RST_BUCKET_SIZE 8'h08
`define LBAA_RST_LEAK_RATE 8'h01

////////////////////////////////////////////////////////////////////////////
// Field positions
`define LBAA_BIT_PHASE_LOSS_EN 7
`define LBAA_LEAK_CODE_MSB 1

////////////////////////////////////////////////////////////////////////////
// Timing
`define LBAA_CYCLE_MS 128
`define LBAA_CLK_KHZ 25000
`define LBAA_CYCLE_CLKS (`LBAA_CYCLE_MS * `LBAA_CLK_KHZ)

`endif

// >>> design/lbaa_bucket.v
// One leaky-bucket accumulator with its own alarm state.
// Assumes i_tick is a one-clock pulse per monitoring cycle and i_fail
// comes from the activity detector on the same clock.
module lbaa_bucket (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Cycle tick and failure indication
    input wire i_tick,
    input wire i_fail,
    // Configuration
    input wire [7:0] i_set_level,
    input wire [7:0] i_clear_level,
    input wire [7:0] i_bucket_size,
    input wire [1:0] i_leak_code,
    // State
    output reg [7:0] o_fill,
    output reg o_alarm
);

reg fail_seen_r;
reg [2:0] leak_cnt_r;
reg [2:0] leak_cnt_nxt;
reg [7:0] fill_nxt;
reg alarm_nxt;
wire failed_cycle;
wire [2:0] leak_last;

// Failure anywhere in the cycle counts, including the tick clock itself
assign failed_cycle = fail_seen_r | i_fail;
// Leak period of 1, 2, 4 or 8 cycles from a two-bit code
assign leak_last = (3'h1 << i_leak_code) - 3'h1;

always @* begin
    fill_nxt = o_fill;
    leak_cnt_nxt = leak_cnt_r;
    if (i_tick) begin // [RL3]
        if (failed_cycle) begin
            leak_cnt_nxt = 3'h0;
            if (o_fill < i_bucket_size) begin
                fill_nxt = o_fill + 8'h01; // [RL4]
            end
        end else if (leak_cnt_r >= leak_last) begin
            leak_cnt_nxt = 3'h0;
            if (o_fill != 8'h00) begin
                fill_nxt = o_fill - 8'h01; // [RL5]
            end
        end else begin
            leak_cnt_nxt = leak_cnt_r + 3'h1; // [RL5]
        end
    end
    // Ceiling lowered below the fill pulls the fill down with it
    if (fill_nxt > i_bucket_size) begin
        fill_nxt = i_bucket_size; // [RL8]
    end
end

always @* begin
    alarm_nxt = o_alarm; // [RL9]
    if (o_fill >= i_set_level) begin
        alarm_nxt = 1'b1; // [RL6]
    end else if (o_fill <= i_clear_level) begin
        alarm_nxt = 1'b0; // [RL7]
    end
end

always @(posedge i_clk) begin
    if (i_reset) begin
        fail_seen_r <= 1'b0;
        leak_cnt_r <= 3'h0;
        o_fill <= 8'h00;
        o_alarm <= 1'b0;
    end else begin
        // New failure at the tick is already counted, so clearing is safe
        fail_seen_r <= i_tick ? 1'b0 : failed_cycle;
        leak_cnt_r <= leak_cnt_nxt;
        o_fill <= fill_nxt;
        o_alarm <= alarm_nxt;
    end
end

endmodule

// >>> design/lbaa_top.v
// Activity alarm with leaky buckets, plus hard-limit phase-loss control.
// Assumes the register port, detector flags and DPLL limit flag are all
// on i_clk; the serial interface decode lives outside.
//
// How it works
// [RL1] Enable set and DPLL at hard limit drives DPLL into phase lost.
// [RL2] Phase-loss enable is bit 7; bits 6..0 unused; resets to 0x8e.
// [RL3] Each accumulator is evaluated once per 128 ms monitoring cycle.
// [RL4] A cycle with failure or erratic input adds exactly one.
// [RL5] Each clean leak period of 1, 2, 4 or 8 cycles subtracts one.
// [RL6] Fill reaching the set level raises the alarm; level resets to 0x06.
// [RL7] Fill decayed to the clear level clears alarm; level resets to 0x04.
// [RL8] Fill saturates at the bucket size; a size lowered below the fill leaves the fill above it for one clock.
// [RL9] Every input has its own fill and alarm, held between the levels.
`include "lbaa_defines.vh"

module lbaa_top #(
    parameter NUM_INPUTS = 2,
    parameter CYCLE_CLKS = `LBAA_CYCLE_CLKS
) (
    // Clock and reset
    input wire i_clk,
    input wire i_reset,
    // Register port
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // Activity detector flags, one per input
    input wire [NUM_INPUTS-1:0] i_input_fail,
    // DPLL side
    input wire i_dpll_at_hard_limit,
    output reg o_dpll_phase_lost,
    // Alarms and monitoring cycle tick
    output reg [NUM_INPUTS-1:0] o_inactivity_alarm,
    output reg o_cycle_tick
);

////////////////////////////////////////////////////////////////////////////
// Configuration registers

reg [7:0] hard_limit_phase_loss_ctrl_r;
reg [7:0] alarm_set_level_r;
reg [7:0] alarm_clear_level_r;
reg [7:0] bucket_size_r;
reg [7:0] leak_rate_r;
wire hard_limit_phase_loss_en;

assign hard_limit_phase_loss_en =
    hard_limit_phase_loss_ctrl_r[`LBAA_BIT_PHASE_LOSS_EN]; // [RL2]

always @(posedge i_clk) begin
    if (i_reset) begin
        hard_limit_phase_loss_ctrl_r <= `LBAA_RST_HARD_LIMIT; // [RL2]
        alarm_set_level_r <= `LBAA_RST_SET_LEVEL; // [RL6]
        alarm_clear_level_r <= `LBAA_RST_CLEAR_LEVEL; // [RL7]
        bucket_size_r <= `LBAA_RST_BUCKET_SIZE;
        leak_rate_r <= `LBAA_RST_LEAK_RATE;
    end else if (i_reg_wr) begin
        case (i_reg_addr)
            `LBAA_ADDR_HARD_LIMIT: begin
                hard_limit_phase_loss_ctrl_r <= i_reg_wdata;
            end
            `LBAA_ADDR_SET_LEVEL: begin
                alarm_set_level_r <= i_reg_wdata;
            end
            `LBAA_ADDR_CLEAR_LEVEL: begin
                alarm_clear_level_r <= i_reg_wdata;
            end
            `LBAA_ADDR_BUCKET_SIZE: begin
                bucket_size_r <= i_reg_wdata;
            end
            `LBAA_ADDR_LEAK_RATE: begin
                leak_rate_r <= i_reg_wdata;
            end
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Monitoring cycle timer

localparam [31:0] CYCLE_LAST = CYCLE_CLKS - 1;

reg [31:0] cycle_cnt_r;
wire cycle_end;

assign cycle_end = (cycle_cnt_r == CYCLE_LAST);

always @(posedge i_clk) begin
    if (i_reset) begin
        cycle_cnt_r <= 32'h0;
        o_cycle_tick <= 1'b0;
    end else begin
        cycle_cnt_r <= cycle_end ? 32'h0 : cycle_cnt_r + 32'h1; // [RL3]
        o_cycle_tick <= cycle_end;
    end
end

////////////////////////////////////////////////////////////////////////////
// Per-input buckets

wire [8*NUM_INPUTS-1:0] fill_all;
wire [NUM_INPUTS-1:0] alarm_all;

genvar gi;
generate
    for (gi = 0; gi < NUM_INPUTS; gi = gi + 1) begin : g_bucket
        lbaa_bucket u_bucket (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_tick(cycle_end),
            .i_fail(i_input_fail[gi]),
            .i_set_level(alarm_set_level_r),
            .i_clear_level(alarm_clear_level_r),
            .i_bucket_size(bucket_size_r),
            .i_leak_code(leak_rate_r[`LBAA_LEAK_CODE_MSB:0]),
            .o_fill(fill_all[8*gi +: 8]),
            .o_alarm(alarm_all[gi])
        ); // [RL9]
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// Outputs

always @(posedge i_clk) begin
    if (i_reset) begin
        o_inactivity_alarm <= {NUM_INPUTS{1'b0}};
        o_dpll_phase_lost <= 1'b0;
    end else begin
        o_inactivity_alarm <= alarm_all;
        // Cleared enable leaves phase-loss to the normal detector
        o_dpll_phase_lost <= hard_limit_phase_loss_en &
            i_dpll_at_hard_limit; // [RL1]
    end
end

////////////////////////////////////////////////////////////////////////////
// Read path, one clock after the strobe; unmapped reads give zero

function [7:0] fill_of;
    input [7:0] addr;
    input [8*NUM_INPUTS-1:0] fills;
    integer k;
    begin
        fill_of = 8'h00;
        for (k = 0; k < NUM_INPUTS; k = k + 1) begin
            if (addr == `LBAA_ADDR_FILL_BASE + k[7:0]) begin
                fill_of = fills[8*k +: 8];
            end
        end
    end
endfunction

reg [7:0] rdata_nxt;
reg [7:0] status_word;

always @* begin
    status_word = 8'h00;
    status_word[NUM_INPUTS-1:0] = alarm_all;
    case (i_reg_addr)
        `LBAA_ADDR_HARD_LIMIT: begin
            rdata_nxt = hard_limit_phase_loss_ctrl_r;
        end
        `LBAA_ADDR_SET_LEVEL: begin
            rdata_nxt = alarm_set_level_r;
        end
        `LBAA_ADDR_CLEAR_LEVEL: begin
            rdata_nxt = alarm_clear_level_r;
        end
        `LBAA_ADDR_BUCKET_SIZE: begin
            rdata_nxt = bucket_size_r;
        end
        `LBAA_ADDR_LEAK_RATE: begin
            rdata_nxt = leak_rate_r;
        end
        `LBAA_ADDR_ALARM_STATUS: begin
            rdata_nxt = status_word;
        end
        default: begin
            rdata_nxt = fill_of(i_reg_addr, fill_all);
        end
    endcase
end

always @(posedge i_clk) begin
    if (i_reset) begin
        o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
        o_reg_rdata <= rdata_nxt;
    end
end

endmodule

// >>> dv/lbaa_checker.sv
// Port-level checks for the activity alarm top.
// Assumes single-clock register strobes and no size change below fill.
`include "lbaa_defines.vh"

module lbaa_checker #(
    parameter NUM_INPUTS = 2,
    parameter CYCLE_CLKS = `LBAA_CYCLE_CLKS
) (
    // Clock, reset, register port
    input wire i_clk,
    input wire i_reset,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    // Detector, DPLL, alarms
    input wire [NUM_INPUTS-1:0] i_input_fail,
    input wire i_dpll_at_hard_limit,
    input wire o_dpll_phase_lost,
    input wire [NUM_INPUTS-1:0] o_inactivity_alarm,
    input wire o_cycle_tick
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    reg en_r;
    reg seen_r;
    reg [7:0] size_r;
    reg [31:0] gap_r;
    // Shadows of the bits the properties depend on
    always @(posedge i_clk) begin
        if (i_reset) begin
            en_r <= 1'b1;
            size_r <= 8'h08;
            seen_r <= 1'b0;
            gap_r <= 0;
        end else begin
            if (i_reg_wr && i_reg_addr == 8'h4c) en_r <= i_reg_wdata[7];
            if (i_reg_wr && i_reg_addr == 8'h52) size_r <= i_reg_wdata;
            seen_r <= seen_r | o_cycle_tick;
            gap_r <= o_cycle_tick ? 0 : gap_r + 1;
        end
    end
    sequence s_rd(a);
        i_reg_rd && i_reg_addr == a;
    endsequence
    property p_pl;
        o_dpll_phase_lost == $past(en_r & i_dpll_at_hard_limit);
    endproperty
    property p_rd;
        s_rd(8'h4c) |=> o_reg_rdata[7] == $past(en_r);
    endproperty
    property p_per;
        o_cycle_tick && seen_r |-> gap_r == CYCLE_CLKS - 1;
    endproperty
    // Alarm output trails the tick pulse by two clocks
    property p_rise;
        $rose(o_inactivity_alarm[0]) |-> $past(o_cycle_tick, 2);
    endproperty
    property p_fall;
        $fell(o_inactivity_alarm[0]) |-> $past(o_cycle_tick, 2);
    endproperty
    property p_hold;
        $changed(o_inactivity_alarm[1]) |-> $past(o_cycle_tick, 2);
    endproperty
    property p_sat0;
        s_rd(8'h58) |=> o_reg_rdata <= $past(size_r);
    endproperty
    property p_sat1;
        s_rd(8'h59) |=> o_reg_rdata <= $past(size_r);
    endproperty
    a_pl: assert property (p_pl) else $error("phase lost wrong");
    a_rd: assert property (p_rd) else $error("enable bit wrong");
    a_per: assert property (p_per) else $error("cycle length");
    a_rise: assert property (p_rise) else $error("alarm set off");
    a_fall: assert property (p_fall) else $error("alarm clr off");
    a_hold: assert property (p_hold) else $error("alarm 1 moved");
    a_sat0: assert property (p_sat0) else $error("fill 0 big");
    a_sat1: assert property (p_sat1) else $error("fill 1 big");
endmodule
bind lbaa_top lbaa_checker #(
    .NUM_INPUTS(NUM_INPUTS), .CYCLE_CLKS(CYCLE_CLKS)
) i_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_input_fail(i_input_fail),
    .i_dpll_at_hard_limit(i_dpll_at_hard_limit),
    .o_dpll_phase_lost(o_dpll_phase_lost),
    .o_inactivity_alarm(o_inactivity_alarm), .o_cycle_tick(o_cycle_tick)
);

// >>> dv/leaky_bucket_activity_alarm_bench.sv
// Self-checking bench for the activity alarm top.
// Assumes an 8-clock monitoring cycle in place of 128 ms.
module leaky_bucket_activity_alarm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    reg clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, lim = 1'b0;
    reg [7:0] addr = 8'h00, wdata = 8'h00;
    reg [1:0] fail = 2'h0;
    wire [7:0] rdata;
    wire [1:0] alarm;
    wire pl, tick;
    integer mismatches = 0, num_checks = 0, cycles = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    lbaa_top #(.NUM_INPUTS(2), .CYCLE_CLKS(8)) i_dut (
        .i_clk(clk), .i_reset(reset), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_input_fail(fail), .i_dpll_at_hard_limit(lim),
        .o_dpll_phase_lost(pl), .o_inactivity_alarm(alarm),
        .o_cycle_tick(tick)
    );
    task automatic chk(input [7:0] got, input [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input [7:0] a, input [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input [7:0] a, input [7:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk(rdata, exp);
    endtask
    // Global timeout bounds this wait
    task automatic wait_tick;
        do @(negedge clk); while (tick !== 1'b1);
    endtask
    task automatic t_reset;
        rd_reg(8'h4c, 8'h8e);
        rd_reg(8'h50, 8'h06);
        rd_reg(8'h51, 8'h04);
        rd_reg(8'h52, 8'h08);
        rd_reg(8'h60, 8'h00);
    endtask
    task automatic t_phase;
        @(negedge clk);
        lim = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, pl}, 8'h01);
        wr_reg(8'h4c, 8'h0e);
        @(negedge clk);
        chk({7'h00, pl}, 8'h00);
        rd_reg(8'h4c, 8'h0e);
    endtask
    task automatic t_bucket;
        integer k;
        wait_tick;
        fail = 2'h1;
        for (k = 1; k <= 10; k = k + 1) begin
            wait_tick;
            rd_reg(8'h58, (k > 8) ? 8'h08 : k[7:0]);
            chk({7'h00, alarm[0]}, {7'h00, k >= 6});
        end
        // Cycle already marked failed; stays full
        fail = 2'h0;
        chk({6'h00, alarm}, 8'h01);
        rd_reg(8'h59, 8'h00);
        repeat (2) wait_tick;
        rd_reg(8'h58, 8'h08);
        wait_tick;
        rd_reg(8'h58, 8'h07);
        wr_reg(8'h53, 8'h00);
        for (k = 6; k >= 3; k = k - 1) begin
            wait_tick;
            rd_reg(8'h58, k[7:0]);
            chk({7'h00, alarm[0]}, {7'h00, k > 4});
        end
    endtask
    // Second input alone, with the slow leak periods of 8 and 4
    task automatic t_second;
        integer k;
        wr_reg(8'h53, 8'h03);
        wait_tick;
        fail = 2'h2;
        for (k = 1; k <= 6; k = k + 1) begin
            wait_tick;
        end
        // Dropped before the next clock, so the next cycle is clean
        fail = 2'h0;
        rd_reg(8'h59, 8'h06);
        rd_reg(8'h54, 8'h02);
        chk({6'h00, alarm}, 8'h02);
        repeat (7) wait_tick;
        rd_reg(8'h59, 8'h06);
        wait_tick;
        rd_reg(8'h59, 8'h05);
        chk({7'h00, alarm[1]}, 8'h01);
        repeat (8) wait_tick;
        rd_reg(8'h59, 8'h04);
        chk({7'h00, alarm[1]}, 8'h00);
        wr_reg(8'h53, 8'h02);
        repeat (3) wait_tick;
        rd_reg(8'h59, 8'h04);
        wait_tick;
        rd_reg(8'h59, 8'h03);
    endtask
    // Mid-run reset restores written registers and empties buckets
    task automatic t_rerun;
        @(negedge clk);
        lim = 1'b0;
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        rd_reg(8'h4c, 8'h8e);
        rd_reg(8'h53, 8'h01);
        rd_reg(8'h59, 8'h00);
        chk({6'h00, alarm}, 8'h00);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_reset;
        t_phase;
        t_bucket;
        t_second;
        t_rerun;
        final_report;
    end
endmodule
